// *** common/cagw_defs.svh ***
// Constants for the cable amplifier gain writer: offsets, fields, resets, timing
`ifndef CAGW_DEFS_SVH
`define CAGW_DEFS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define CAGW_IDX_RESET 6'h00
`define CAGW_IDX_CTRL 6'h0F
`define CAGW_IDX_GAIN0 6'h13
`define CAGW_IDX_GAIN1 6'h17
`define CAGW_IDX_GAIN2 6'h1B
`define CAGW_IDX_GAIN3 6'h1F
`define CAGW_IDX_PROFILE 6'h20
`define CAGW_IDX_STATUS 6'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAGW_BIT_SOFT_RESET 5
`define CAGW_BIT_GAIN_MODE 0
`define CAGW_STAT_BUSY 10

// ----------------------------------------------------------------
// Reset values and answers
// ----------------------------------------------------------------
`define CAGW_GAIN_RST 8'h00
`define CAGW_PROFILE_RST 2'h0
`define CAGW_RESP_OKAY 2'h0
`define CAGW_RESP_DECERR 2'h3

// ----------------------------------------------------------------
// Timing in master clock cycles
// ----------------------------------------------------------------
`define CAGW_SETTLE_MIN_CYC 48
`define CAGW_SETTLE_MAX_CYC 64
`define CAGW_SETTLE_CYC (`CAGW_SETTLE_MIN_CYC + 2)
`define CAGW_TRANSFER_MAX_CYC 200

`endif

// *** common/cagw_pkg.sv ***
// Types shared by the cable amplifier gain writer
package cagw_pkg;

   // Master clock side: wait for a stable gain, then hand it over
   typedef enum logic [1:0] {
      CTL_IDLE = 2'b00,
      CTL_SETTLE = 2'b01,
      CTL_SEND = 2'b11
   } cagw_ctl_state_t;

   // Link side: serial shifter
   typedef enum logic [1:0] {
      LNK_IDLE = 2'b00,
      LNK_LOW = 2'b01,
      LNK_HIGH = 2'b11,
      LNK_END = 2'b10
   } cagw_lnk_state_t;

endpackage

// *** hdl/cagw_gain_writer.sv ***
// Cable amplifier gain writer: profile gain registers and 3-wire serial sender
`timescale 1ns/10ps
`default_nettype none
`include "cagw_defs.svh"

module cagw_gain_writer #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic linkClk,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic profilePin,
   output logic ampWriteEnableN,
   output logic ampSerialClk,
   output logic ampSerialData
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // Bit 2 marks a gain register, bits 1:0 name its profile
   function automatic logic [2:0] gainSlot(input logic [5:0] idx);
      case (idx)
         `CAGW_IDX_GAIN0: gainSlot = 3'b100;
         `CAGW_IDX_GAIN1: gainSlot = 3'b101;
         `CAGW_IDX_GAIN2: gainSlot = 3'b110;
         `CAGW_IDX_GAIN3: gainSlot = 3'b111;
         default: gainSlot = 3'b000;
      endcase
   endfunction

   function automatic logic isMapped(input logic [5:0] idx);
      logic [2:0] slot;
      slot = gainSlot(idx);
      case (idx)
         `CAGW_IDX_RESET, `CAGW_IDX_CTRL, `CAGW_IDX_PROFILE,
         `CAGW_IDX_STATUS: isMapped = 1'b1;
         default: isMapped = slot[2];
      endcase
   endfunction

   // Narrow mode drives a 6-bit gain field; the upper bits go out as zero
   function automatic logic [7:0] shapeGain(input logic [7:0] raw, input logic mode);
      shapeGain = mode ? {2'b00, raw[5:0]} : raw;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic profilePinMeta_q;
   logic profilePinSync_q;
   logic awReady_q;
   logic wReady_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [5:0] awIdx_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic arReady_q;
   logic rValid_q;
   logic [31:0] rData_q;
   logic [1:0] rResp_q;
   logic [7:0] gain_q [4];
   logic gainMode_q;
   logic [1:0] profileSel_q;
   logic doWrite;
   logic softRst;
   logic [2:0] wrSlot;
   logic [5:0] arIdx;
   logic [2:0] rdSlot;
   logic [1:0] curProfile;
   logic [7:0] target;
   logic [7:0] tracked_q;
   logic [7:0] lastSent_q;
   logic [7:0] txWord_q;
   logic forceSend_q;
   logic [6:0] settleCnt_q;
   logic req_q;
   logic ackMeta_q;
   logic ackSync_q;
   logic changed;
   cagw_pkg::cagw_ctl_state_t ctlState_q;
   logic linkRstMeta_q;
   logic linkRst_q;
   logic reqMeta_q;
   logic reqSync_q;
   logic reqSeen_q;
   logic ack_q;
   logic [7:0] shift_q;
   logic [2:0] bitCnt_q;
   logic enN_q;
   logic sclk_q;
   logic sdata_q;
   cagw_pkg::cagw_lnk_state_t lnkState_q;

   // ----------------------------------------------------------------
   // Profile pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         profilePinMeta_q <= 1'b0;
         profilePinSync_q <= 1'b0;
      end else begin
         profilePinMeta_q <= profilePin;
         profilePinSync_q <= profilePinMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------------------------------
   // Address and data are taken in either order; the write happens once both are held
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;
   assign softRst = doWrite && (awIdx_q == `CAGW_IDX_RESET) && wStrb_q[0]
                    && wData_q[`CAGW_BIT_SOFT_RESET];
   assign wrSlot = gainSlot(awIdx_q);

   always_ff @(posedge clk) begin
      if (srst) begin
         awReady_q <= 1'b1;
         wReady_q <= 1'b1;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awIdx_q <= 6'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= `CAGW_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awReady_q) begin
            awIdx_q <= s_axi_awaddr[7:2];
            awHeld_q <= 1'b1;
            awReady_q <= 1'b0;
         end
         if (s_axi_wvalid && wReady_q) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHeld_q <= 1'b1;
            wReady_q <= 1'b0;
         end
         if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q <= isMapped(awIdx_q) ? `CAGW_RESP_OKAY : `CAGW_RESP_DECERR;
         end
         if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Gain, mode and profile registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || softRst) begin
         for (int p = 0; p < 4; p++) begin
            gain_q[p] <= `CAGW_GAIN_RST;
         end
         profileSel_q <= `CAGW_PROFILE_RST;
      end else if (doWrite && wStrb_q[0]) begin
         if (wrSlot[2]) begin
            gain_q[wrSlot[1:0]] <= wData_q[7:0];
         end
         if (awIdx_q == `CAGW_IDX_PROFILE) begin
            profileSel_q <= wData_q[1:0];
         end
      end
   end

   // Mode survives a soft reset; only the hardware reset clears it
   always_ff @(posedge clk) begin
      if (srst) begin
         gainMode_q <= 1'b0;
      end else if (doWrite && wStrb_q[0] && awIdx_q == `CAGW_IDX_CTRL) begin
         gainMode_q <= wData_q[`CAGW_BIT_GAIN_MODE];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channels
   // ----------------------------------------------------------------
   assign arIdx = s_axi_araddr[7:2];
   assign rdSlot = gainSlot(arIdx);

   always_ff @(posedge clk) begin
      if (srst) begin
         arReady_q <= 1'b1;
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= `CAGW_RESP_OKAY;
      end else if (s_axi_arvalid && arReady_q) begin
         arReady_q <= 1'b0;
         rValid_q <= 1'b1;
         rResp_q <= isMapped(arIdx) ? `CAGW_RESP_OKAY : `CAGW_RESP_DECERR;
         rData_q <= 32'h0000_0000;
         if (rdSlot[2]) begin
            rData_q[7:0] <= gain_q[rdSlot[1:0]];
         end
         case (arIdx)
            `CAGW_IDX_CTRL: rData_q[`CAGW_BIT_GAIN_MODE] <= gainMode_q;
            `CAGW_IDX_PROFILE: rData_q[1:0] <= profileSel_q;
            `CAGW_IDX_STATUS: begin
               rData_q[7:0] <= lastSent_q;
               rData_q[9:8] <= curProfile;
               rData_q[`CAGW_STAT_BUSY] <= (ctlState_q != cagw_pkg::CTL_IDLE);
            end
            default: ;
         endcase
      end else if (rValid_q && s_axi_rready) begin
         rValid_q <= 1'b0;
         arReady_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Gain tracking and transfer trigger
   // ----------------------------------------------------------------
   // A profile change with an unchanged gain leaves the target unchanged
   assign curProfile = {profileSel_q[1], profileSel_q[0] ^ profilePinSync_q};
   assign target = shapeGain(gain_q[curProfile], gainMode_q);
   assign changed = (target != tracked_q);

   always_ff @(posedge clk) begin
      if (srst) begin
         tracked_q <= `CAGW_GAIN_RST;
      end else begin
         tracked_q <= target;
      end
   end

   // Each change restarts the settle wait, so only a stable value is sent
   always_ff @(posedge clk) begin
      if (srst) begin
         ctlState_q <= cagw_pkg::CTL_IDLE;
         settleCnt_q <= 7'h00;
         forceSend_q <= 1'b1;
         lastSent_q <= `CAGW_GAIN_RST;
         txWord_q <= `CAGW_GAIN_RST;
         req_q <= 1'b0;
      end else begin
         case (ctlState_q)
            cagw_pkg::CTL_IDLE: begin
               settleCnt_q <= 7'h00;
               if (changed || forceSend_q) begin
                  ctlState_q <= cagw_pkg::CTL_SETTLE;
               end
            end
            cagw_pkg::CTL_SETTLE: begin
               if (changed) begin
                  settleCnt_q <= 7'h00;
               end else if (settleCnt_q == 7'(`CAGW_SETTLE_CYC - 1)) begin
                  settleCnt_q <= 7'h00;
                  if (target != lastSent_q || forceSend_q) begin
                     txWord_q <= target;
                     req_q <= ~req_q;
                     ctlState_q <= cagw_pkg::CTL_SEND;
                  end else begin
                     ctlState_q <= cagw_pkg::CTL_IDLE;
                  end
               end else begin
                  settleCnt_q <= settleCnt_q + 7'h01;
               end
            end
            cagw_pkg::CTL_SEND: begin
               // Word stays put until the link side hands back the toggle
               if (ackSync_q == req_q) begin
                  lastSent_q <= txWord_q;
                  forceSend_q <= 1'b0;
                  settleCnt_q <= 7'h00;
                  if (target != txWord_q) begin
                     ctlState_q <= cagw_pkg::CTL_SETTLE;
                  end else begin
                     ctlState_q <= cagw_pkg::CTL_IDLE;
                  end
               end
            end
            default: ctlState_q <= cagw_pkg::CTL_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ackMeta_q <= 1'b0;
         ackSync_q <= 1'b0;
      end else begin
         ackMeta_q <= ack_q;
         ackSync_q <= ackMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // Link domain: reset and request synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge linkClk) begin
      linkRstMeta_q <= srst;
      linkRst_q <= linkRstMeta_q;
   end

   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         reqMeta_q <= 1'b0;
         reqSync_q <= 1'b0;
      end else begin
         reqMeta_q <= req_q;
         reqSync_q <= reqMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // Link domain: serial shifter
   // ----------------------------------------------------------------
   // Data moves on the falling clock edge so the amplifier sees it settled at the rise
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         lnkState_q <= cagw_pkg::LNK_IDLE;
         reqSeen_q <= 1'b0;
         ack_q <= 1'b0;
         shift_q <= 8'h00;
         bitCnt_q <= 3'h0;
         enN_q <= 1'b1;
         sclk_q <= 1'b0;
         sdata_q <= 1'b0;
      end else begin
         case (lnkState_q)
            cagw_pkg::LNK_IDLE: begin
               // New request only when idle, so nothing cuts a word short
               if (reqSync_q != reqSeen_q) begin
                  reqSeen_q <= reqSync_q;
                  shift_q <= {txWord_q[6:0], 1'b0};
                  sdata_q <= txWord_q[7];
                  enN_q <= 1'b0;
                  bitCnt_q <= 3'h0;
                  lnkState_q <= cagw_pkg::LNK_LOW;
               end
            end
            cagw_pkg::LNK_LOW: begin
               sclk_q <= 1'b1;
               lnkState_q <= cagw_pkg::LNK_HIGH;
            end
            cagw_pkg::LNK_HIGH: begin
               sclk_q <= 1'b0;
               if (bitCnt_q == 3'h7) begin
                  lnkState_q <= cagw_pkg::LNK_END;
               end else begin
                  sdata_q <= shift_q[7];
                  shift_q <= {shift_q[6:0], 1'b0};
                  bitCnt_q <= bitCnt_q + 3'h1;
                  lnkState_q <= cagw_pkg::LNK_LOW;
               end
            end
            cagw_pkg::LNK_END: begin
               enN_q <= 1'b1;
               sdata_q <= 1'b0;
               ack_q <= reqSeen_q;
               lnkState_q <= cagw_pkg::LNK_IDLE;
            end
            default: lnkState_q <= cagw_pkg::LNK_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign ampWriteEnableN = enN_q;
   assign ampSerialClk = sclk_q;
   assign ampSerialData = sdata_q;

endmodule
`default_nettype wire

// *** verif/cagw_amp_model.sv ***
// Behavioural model of the amplifier at the far end of the 3-wire link
`timescale 1ns/10ps
`default_nettype none
module cagw_amp_model (
   input wire logic enN,
   input wire logic sclk,
   input wire logic sdata,
   output var logic [7:0] gain,
   output var int words,
   output var int bits
);
   logic [7:0] shiftQ = 8'h00;
   initial gain = 8'h00;
   initial words = 0;
   initial bits = 0;
   always @(posedge sclk) begin
      if (enN === 1'b0) begin
         shiftQ <= {shiftQ[6:0], sdata};
         bits <= bits + 1;
      end
   end
   always @(negedge enN) bits <= 0;
   // Gain only moves on the closing enable edge, never on a stray rise
   always @(posedge enN) begin
      if (bits != 0) begin
         gain <= shiftQ;
         words <= words + 1;
      end
   end
endmodule
`default_nettype wire

// *** verif/cagw_gain_writer_props.sv ***
// Concurrent checks on the gain writer's ports
`timescale 1ns/10ps
`default_nettype none
module cagw_gain_writer_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic linkClk,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic ampWriteEnableN,
   input wire logic ampSerialClk,
   input wire logic ampSerialData
);
   wire en = ampWriteEnableN;
   wire sck = ampSerialClk;
   wire sd = ampSerialData;
   logic [4:0] pulseCnt_q;
   // Clock pulses seen in the current frame
   always_ff @(posedge linkClk) begin
      if (srst || en) begin
         pulseCnt_q <= 5'h00;
      end else if (sck) begin
         pulseCnt_q <= pulseCnt_q + 5'h01;
      end
   end
   enWindow_a: assert property (@(posedge linkClk) disable iff (srst)
      $fell(en) |-> !en[*8] ##1 !en[*8] ##1 !en ##1 en) else $error("enable frame length");
   pulseCount_a: assert property (@(posedge linkClk) disable iff (srst)
      $rose(en) |-> pulseCnt_q == 5'h08) else $error("clock pulse count per frame");
   clkInFrame_a: assert property (@(posedge linkClk) disable iff (srst)
      sck |-> !en) else $error("serial clock outside frame");
   clkPulse_a: assert property (@(posedge linkClk) disable iff (srst)
      sck |=> !sck) else $error("serial clock pulse too long");
   dataHold_a: assert property (@(posedge linkClk) disable iff (srst)
      sck |-> $stable(sd)) else $error("data moved while clock high");
   idleLow_a: assert property (@(posedge linkClk) disable iff (srst)
      en |-> !sd && !sck) else $error("link not idle outside frame");
   frameGap_a: assert property (@(posedge linkClk) disable iff (srst)
      $rose(en) |=> en[*8]) else $error("frames too close");
   frameEnds_a: assert property (@(posedge clk) disable iff (srst)
      $fell(en) |-> ##[1:4] en) else $error("frame did not end");
   readAnswer_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   respHold_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_bvalid |-> !s_axi_awready) else $error("address taken during response");
   cover property (@(posedge linkClk) $rose(en));
   cover property (@(posedge clk) s_axi_bvalid);
   cover property (@(posedge clk) s_axi_rvalid);
endmodule
bind cagw_gain_writer cagw_gain_writer_props u_props (.clk, .srst, .linkClk, .s_axi_awready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ampWriteEnableN,
   .ampSerialClk, .ampSerialData);
`default_nettype wire

// *** verif/test_cable_amp_gain_writer.sv ***
// Self-checking bench for the cable amplifier gain writer
`timescale 1ns/10ps
`default_nettype none
`include "cagw_defs.svh"
module test_cable_amp_gain_writer;
   localparam logic [1:0] OK = `CAGW_RESP_OKAY;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic profilePin = 1'b0;
   logic ampWriteEnableN;
   logic ampSerialClk;
   logic ampSerialData;
   logic [7:0] ampGain;
   int ampWords;
   int ampBits;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [5:0] gIdx [4] = '{`CAGW_IDX_GAIN0, `CAGW_IDX_GAIN1, `CAGW_IDX_GAIN2, `CAGW_IDX_GAIN3};
   logic [7:0] pGain [4] = '{8'ha5, 8'h3c, 8'hc3, 8'h81};
   always #50 clk = ~clk;
   always #7.5 linkClk = ~linkClk;
   cagw_gain_writer dut (.clk, .srst, .linkClk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .profilePin, .ampWriteEnableN, .ampSerialClk,
      .ampSerialData);
   cagw_amp_model amp (.enN(ampWriteEnableN), .sclk(ampSerialClk), .sdata(ampSerialData),
      .gain(ampGain), .words(ampWords), .bits(ampBits));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Run is under two thousand cycles; this only cuts a hang
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bus waits last as long as the slave needs; only the watchdog ends a hang
   task automatic axiWr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic axiRd(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check("rdata", 32'(d), s_axi_rdata);
      check("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   // Start delay counted from the call, which follows the trigger closely
   task automatic expectWord(input logic [7:0] exp, input int lo);
      int t;
      int n0;
      t = 0;
      n0 = ampWords;
      while (ampWriteEnableN !== 1'b0 && t < 100) begin
         @(posedge clk);
         t++;
      end
      check("start delay in range", 32'h0000_0001, 32'(t >= lo && t <= 64));
      repeat (5) @(posedge clk);
      check("word count", 32'(n0 + 1), 32'(ampWords));
      check("amp gain", 32'(exp), 32'(ampGain));
      check("bit count", 32'h0000_0008, 32'(ampBits));
   endtask
   task automatic expectNone();
      int n0;
      n0 = ampWords;
      repeat (90) @(posedge clk);
      check("no transfer", 32'(n0), 32'(ampWords));
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic tPowerUp();
      expectWord(8'h00, 46);
      for (int i = 0; i < 4; i++) axiRd(gIdx[i], 8'h00, OK);
      $display("test power-up done");
   endtask
   task automatic tWrite();
      axiWr(gIdx[0], pGain[0], OK);
      expectWord(pGain[0], 45);
      axiRd(gIdx[0], pGain[0], OK);
      axiWr(gIdx[0], pGain[0], OK);
      expectNone();
      $display("test gain write done");
   endtask
   task automatic tProfile();
      for (int p = 1; p < 4; p++) axiWr(gIdx[p], pGain[p], OK);
      expectNone();
      for (int p = 1; p < 4; p++) begin
         axiWr(`CAGW_IDX_PROFILE, 8'(p), OK);
         expectWord(pGain[p], 45);
      end
      @(posedge clk);
      profilePin <= 1'b1;
      expectWord(pGain[2], 44);
      @(posedge clk);
      profilePin <= 1'b0;
      expectWord(pGain[3], 44);
      axiWr(gIdx[2], pGain[3], OK);
      expectNone();
      @(posedge clk);
      profilePin <= 1'b1;
      expectNone();
      @(posedge clk);
      profilePin <= 1'b0;
      expectNone();
      axiRd(`CAGW_IDX_STATUS, 32'h0000_0381, OK);
      $display("test profile change done");
   endtask
   task automatic tMode();
      axiWr(`CAGW_IDX_CTRL, 8'h01, OK);
      expectWord(pGain[3] & 8'h3f, 45);
      axiRd(`CAGW_IDX_CTRL, 32'h0000_0001, OK);
      axiWr(`CAGW_IDX_CTRL, 8'h00, OK);
      expectWord(pGain[3], 45);
      $display("test gain mode done");
   endtask
   task automatic tInFlight();
      int t;
      t = 0;
      axiWr(gIdx[3], 8'h5a, OK);
      while (ampWriteEnableN !== 1'b0 && t < 100) begin
         @(posedge clk);
         t++;
      end
      axiWr(gIdx[3], 8'h66, OK);
      repeat (4) @(posedge clk);
      check("word in flight", 32'h0000_005a, 32'(ampGain));
      check("bits in flight", 32'h0000_0008, 32'(ampBits));
      expectWord(8'h66, 40);
      $display("test write during transfer done");
   endtask
   task automatic tSoftReset();
      axiWr(`CAGW_IDX_RESET, 8'h20, OK);
      expectWord(8'h00, 45);
      axiRd(`CAGW_IDX_PROFILE, 8'h00, OK);
      for (int i = 0; i < 4; i++) axiRd(gIdx[i], 8'h00, OK);
      axiWr(`CAGW_IDX_RESET, 8'h20, OK);
      expectNone();
      axiRd(6'h05, 8'h00, `CAGW_RESP_DECERR);
      axiWr(6'h05, 8'hff, `CAGW_RESP_DECERR);
      expectNone();
      $display("test soft reset done");
   endtask
   // Hardware reset in mid-run always sends zero, whatever went out before
   task automatic tHwReset();
      axiWr(gIdx[0], 8'h42, OK);
      expectWord(8'h42, 45);
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      expectWord(8'h00, 46);
      axiRd(gIdx[0], 32'h0000_0000, OK);
      $display("test hardware reset done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      tPowerUp();
      tWrite();
      tProfile();
      tMode();
      tInFlight();
      tSoftReset();
      tHwReset();
      conclude();
   end
endmodule
`default_nettype wire
